// ---- design/vectored_interrupt_control.sv ----
// Vectored interrupt control: request flags, masks, priority and entry sequence
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
module vectored_interrupt_control #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  // Interrupt sources
  input  wire logic              extIrqZeroN,
  input  wire logic              extIrqOneN,
  input  wire logic [2:0]        timerOverflow,
  input  wire logic              adcDone,
  input  wire logic              serialDone,
  input  wire logic              stopMode,
  input  wire logic              stopCancelInput,
  // Core bit operations on locations 0-3
  input  wire logic              bitOpValid,
  input  wire logic [1:0]        bitOpCode,
  input  wire logic [1:0]        bitOpAddr,
  input  wire logic [1:0]        bitOpBit,
  output logic                   bitTestValid,
  output logic                   bitTestResult,
  // Core sequencer
  input  wire logic              instrBoundary,
  input  wire logic              returnFromIrqInstr,
  output logic                   finishInstr,
  output logic                   pushStack,
  output logic                   loadVector,
  output logic      [13:0]       vectorAddr,
  output logic                   restoreFlags,
  output logic      [1:0]        seqCycle,
  // Summary interrupt
  output logic                   irqOut
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int NUM_SRC = irq_ctrl_pkg::NUM_SRC;

  logic [15:0]                 ctrl_q;
  logic [15:0]                 ctrl_d;
  logic [NUM_SRC-1:0]          hwSet;
  logic [NUM_SRC-1:0]          flags;
  logic [NUM_SRC-1:0]          masks;
  logic [NUM_SRC-1:0]          pending;
  logic [2:0]                  winner;
  logic                        anyPending;
  logic [1:0]                  extRise;
  logic [1:0]                  stopSync_q;
  logic                        stopLast_q;
  logic                        stopRise;
  irq_ctrl_pkg::seq_state_e    state_q;
  irq_ctrl_pkg::seq_state_e    state_d;
  logic [13:0]                 vector_q;
  logic                        loadVector_q;
  logic                        restoreFlags_q;
  logic                        bitTestValid_q;
  logic                        bitTestResult_q;
  logic [ADDR_W-1:0]           wrAddr_q;
  logic                        wrPend_q;
  logic [31:0]                 hrdata_q;
  logic [irq_ctrl_pkg::EV_W-1:0] evStat_q;
  logic [irq_ctrl_pkg::EV_W-1:0] evMask_q;
  logic [irq_ctrl_pkg::EV_W-1:0] events;
  logic                        addrPhase;
  logic                        rdStat;
  logic [3:0]                  nibbleOut;

  // ****************************************
  // Source events
  // ****************************************
  // Pins are active low; a rising level at the pin is the documented trigger
  pin_edge_sync #(.W(2)) u_pins (
    .clk_sys (clk_sys),
    .srst    (srst),
    .pinIn   ({extIrqOneN, extIrqZeroN}),
    .riseOut (extRise)
  );

  // Same-clock pulses need no synchroniser
  assign hwSet = {serialDone, adcDone, timerOverflow, extRise};

  // ****************************************
  // Flags, masks and priority
  // ****************************************
  genvar s;
  generate
    for (s = 0; s < NUM_SRC; s++)
    begin : g_src
      assign flags[s] = ctrl_q[irq_ctrl_pkg::FLAG_POS0 + irq_ctrl_pkg::POS_STEP * s];
      assign masks[s] = ctrl_q[irq_ctrl_pkg::MASK_POS0 + irq_ctrl_pkg::POS_STEP * s];
    end
  endgenerate

  assign pending    = flags & ~masks;
  assign anyPending = |pending;

  // Lowest index wins: external 0 first, serial last
  always_comb
  begin
    winner = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        winner = 3'(i);
      end
    end
  end

  // ****************************************
  // Control bit update
  // ****************************************
  always_comb
  begin
    ctrl_d = ctrl_q;
    // Bus write: enable and masks follow data, flags may only be cleared
    if (wrPend_q && (wrAddr_q[ADDR_W-1:2] <= ADDR_W'(irq_ctrl_pkg::IDX_CTRL3)))
    begin
      for (int b = 0; b < 4; b++)
      begin
        if ((b == 2) || ((b == 0) && (wrAddr_q[3:2] != 2'h0)))
        begin
          ctrl_d[{wrAddr_q[3:2], 2'(b)}] = ctrl_q[{wrAddr_q[3:2], 2'(b)}] & hwdata[b];
        end
        else if (b != 1 || wrAddr_q[3:2] != 2'h0)
        begin
          ctrl_d[{wrAddr_q[3:2], 2'(b)}] = hwdata[b];
        end
      end
    end
    // Core bit operations; a set aimed at a flag is dropped
    if (bitOpValid && (bitOpCode == irq_ctrl_pkg::BITOP_SET))
    begin
      if (bitOpBit[0] || ({bitOpAddr, bitOpBit} == 4'h0))
      begin
        ctrl_d[{bitOpAddr, bitOpBit}] = 1'b1;
      end
    end
    if (bitOpValid && (bitOpCode == irq_ctrl_pkg::BITOP_RESET))
    begin
      ctrl_d[{bitOpAddr, bitOpBit}] = 1'b0;
    end
    if (returnFromIrqInstr)
    begin
      ctrl_d[irq_ctrl_pkg::IE_POS] = 1'b1;
    end
    if (state_q == irq_ctrl_pkg::SEQ_CYC2)
    begin
      ctrl_d[irq_ctrl_pkg::IE_POS] = 1'b0;
    end
    ctrl_d[1] = 1'b0;
    // Hardware set wins over any clear in the same cycle
    for (int k = 0; k < NUM_SRC; k++)
    begin
      if (hwSet[k])
      begin
        ctrl_d[irq_ctrl_pkg::FLAG_POS0 + irq_ctrl_pkg::POS_STEP * k] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_q <= irq_ctrl_pkg::CTRL_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // Bit test answer one cycle after the request
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      bitTestValid_q  <= 1'b0;
      bitTestResult_q <= 1'b0;
    end
    else
    begin
      bitTestValid_q  <= bitOpValid && (bitOpCode == irq_ctrl_pkg::BITOP_TEST);
      bitTestResult_q <= ctrl_q[{bitOpAddr, bitOpBit}];
    end
  end

  // ****************************************
  // Entry sequence
  // ****************************************
  always_comb
  begin
    case (state_q)
      irq_ctrl_pkg::SEQ_IDLE:
      begin
        // Only at a boundary, and only one sequence in flight
        if (instrBoundary && anyPending && ctrl_q[irq_ctrl_pkg::IE_POS])
        begin
          state_d = irq_ctrl_pkg::SEQ_CYC1;
        end
        else
        begin
          state_d = irq_ctrl_pkg::SEQ_IDLE;
        end
      end
      irq_ctrl_pkg::SEQ_CYC1: state_d = irq_ctrl_pkg::SEQ_CYC2;
      irq_ctrl_pkg::SEQ_CYC2: state_d = irq_ctrl_pkg::SEQ_CYC3;
      irq_ctrl_pkg::SEQ_CYC3: state_d = irq_ctrl_pkg::SEQ_IDLE;
      default:                state_d = irq_ctrl_pkg::SEQ_IDLE;
    endcase
  end

  // Stop cancel: two-stage sync before the edge detect
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      stopSync_q <= 2'h0;
      stopLast_q <= 1'b0;
    end
    else
    begin
      stopSync_q <= {stopSync_q[0], stopCancelInput};
      stopLast_q <= stopSync_q[1];
    end
  end
  assign stopRise = stopSync_q[1] & ~stopLast_q & stopMode;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_q        <= irq_ctrl_pkg::SEQ_IDLE;
      vector_q       <= irq_ctrl_pkg::VEC_RESET;
      loadVector_q   <= 1'b0;
      restoreFlags_q <= 1'b0;
    end
    else
    begin
      state_q        <= state_d;
      restoreFlags_q <= returnFromIrqInstr;
      loadVector_q   <= (state_d == irq_ctrl_pkg::SEQ_CYC3) || stopRise;
      // Winner frozen at acceptance so a later request cannot steer this entry
      if (state_q == irq_ctrl_pkg::SEQ_IDLE && state_d == irq_ctrl_pkg::SEQ_CYC1)
      begin
        vector_q <= irq_ctrl_pkg::VEC_FIRST + 14'(winner) * irq_ctrl_pkg::VEC_STEP;
      end
      else if (stopRise && state_q == irq_ctrl_pkg::SEQ_IDLE)
      begin
        vector_q <= irq_ctrl_pkg::VEC_RESET;
      end
    end
  end

  assign finishInstr  = (state_q == irq_ctrl_pkg::SEQ_CYC1);
  assign pushStack    = (state_q == irq_ctrl_pkg::SEQ_CYC2) ||
                        (state_q == irq_ctrl_pkg::SEQ_CYC3);
  assign loadVector   = loadVector_q;
  assign vectorAddr   = vector_q;
  assign restoreFlags = restoreFlags_q;
  assign seqCycle     = state_q;
  assign bitTestValid  = bitTestValid_q;
  assign bitTestResult = bitTestResult_q;

  // ****************************************
  // Event status, mask and summary output
  // ****************************************
  assign events[irq_ctrl_pkg::EV_SEQ] = (state_q == irq_ctrl_pkg::SEQ_CYC1);
  assign events[irq_ctrl_pkg::EV_RET] = returnFromIrqInstr;

  assign addrPhase = hsel && htrans[1] && hready;
  assign rdStat    = addrPhase && !hwrite && (haddr == ADDR_W'(irq_ctrl_pkg::ADDR_EVSTAT));

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      evStat_q <= '0;
    end
    else
    begin
      // Read clears, a new event in the same cycle stays set
      evStat_q <= (rdStat ? '0 : evStat_q) | events;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      evMask_q <= irq_ctrl_pkg::EVMASK_RESET;
    end
    else if (wrPend_q && (wrAddr_q == ADDR_W'(irq_ctrl_pkg::ADDR_EVMASK)))
    begin
      evMask_q <= hwdata[irq_ctrl_pkg::EV_W-1:0];
    end
  end

  assign irqOut = |(evStat_q & evMask_q);

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  assign nibbleOut = ctrl_q[{haddr[3:2], 2'h0} +: 4];

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      wrPend_q <= addrPhase && hwrite;
      if (addrPhase)
      begin
        wrAddr_q <= haddr;
      end
      if (addrPhase && !hwrite)
      begin
        // Read data captured in the address phase; unmapped words read zero
        if (haddr[ADDR_W-1:2] <= ADDR_W'(irq_ctrl_pkg::IDX_CTRL3))
        begin
          hrdata_q <= {28'h0, nibbleOut};
        end
        else if (haddr == ADDR_W'(irq_ctrl_pkg::ADDR_EVSTAT))
        begin
          hrdata_q <= {30'h0, evStat_q};
        end
        else if (haddr == ADDR_W'(irq_ctrl_pkg::ADDR_EVMASK))
        begin
          hrdata_q <= {30'h0, evMask_q};
        end
        else if (haddr == ADDR_W'(irq_ctrl_pkg::ADDR_SEQSTAT))
        begin
          hrdata_q <= {4'h0, vector_q, 6'h0, anyPending, 1'b0, 2'(state_q), 4'h0};
        end
        else
        begin
          hrdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

endmodule

// ---- design/irq_ctrl_pkg.sv ----
// Constants, field layout and state encoding for the vectored interrupt control
package irq_ctrl_pkg;

  // ****************************************
  // Sources and control-bit layout
  // ****************************************
  localparam int          NUM_SRC    = 7;
  localparam int          SRC_EXT0   = 0;
  localparam int          SRC_EXT1   = 1;
  localparam int          SRC_TMRA   = 2;
  localparam int          SRC_ADC    = 5;
  localparam int          SRC_SERIAL = 6;
  localparam int          CTRL_BITS  = 16;
  localparam int          IE_POS     = 0;
  localparam int          FLAG_POS0  = 2;
  localparam int          MASK_POS0  = 3;
  localparam int          POS_STEP   = 2;
  localparam logic [15:0] CTRL_RESET = 16'hAAA8;

  // ****************************************
  // Vectors
  // ****************************************
  localparam int          PC_W      = 14;
  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_FIRST = 14'h0002;
  localparam logic [13:0] VEC_STEP  = 14'h0002;

  // ****************************************
  // Bit operations from the core
  // ****************************************
  localparam logic [1:0] BITOP_SET   = 2'h0;
  localparam logic [1:0] BITOP_RESET = 2'h1;
  localparam logic [1:0] BITOP_TEST  = 2'h2;

  // ****************************************
  // Bus register map
  // ****************************************
  localparam logic [7:0] IDX_CTRL0    = 8'h00;
  localparam logic [7:0] IDX_CTRL3    = 8'h03;
  localparam logic [7:0] ADDR_EVSTAT  = 8'h10;
  localparam logic [7:0] ADDR_EVMASK  = 8'h14;
  localparam logic [7:0] ADDR_SEQSTAT = 8'h18;
  localparam int         EV_W         = 2;
  localparam int         EV_SEQ       = 0;
  localparam int         EV_RET       = 1;
  localparam logic [1:0] EVMASK_RESET = 2'h0;

  // ****************************************
  // Sequence states
  // ****************************************
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_CYC1 = 2'h1,
    SEQ_CYC2 = 2'h3,
    SEQ_CYC3 = 2'h2
  } seq_state_e;

endpackage

// ---- design/pin_edge_sync.sv ----
// Two-stage synchroniser with rising-edge detect for asynchronous pins
`timescale 1ns/100ps
module pin_edge_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         srst,
  // Pins and edges
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] riseOut
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_pin
      // Only the second stage and its delayed copy feed the edge detect
      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          // Pins idle high; resetting to that level avoids a false edge
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
          last_q[i] <= 1'b1;
        end
        else
        begin
          meta_q[i] <= pinIn[i];
          sync_q[i] <= meta_q[i];
          last_q[i] <= sync_q[i];
        end
      end
      assign riseOut[i] = sync_q[i] & ~last_q[i];
    end
  endgenerate

endmodule

// ---- tb/irq_ctrl_sva.sv ----
// Checker for the entry sequence, bit tests and bus response
`timescale 1ns/100ps
module irq_ctrl_sva (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // Bus and bit ops
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        bitOpValid,
  input wire logic [1:0]  bitOpCode,
  input wire logic        bitTestValid,
  // Sequencer
  input wire logic        instrBoundary,
  input wire logic        returnFromIrqInstr,
  input wire logic        finishInstr,
  input wire logic        pushStack,
  input wire logic        loadVector,
  input wire logic [13:0] vectorAddr,
  input wire logic        restoreFlags,
  input wire logic [1:0]  seqCycle
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence s_tail;
    seqCycle == irq_ctrl_pkg::SEQ_CYC2 ##1 seqCycle == irq_ctrl_pkg::SEQ_CYC3
      ##1 seqCycle == irq_ctrl_pkg::SEQ_IDLE;
  endsequence
  sequence s_vecHold;
    $stable(vectorAddr) [*2];
  endsequence

  chk_seq_order: assert property (seqCycle == irq_ctrl_pkg::SEQ_CYC1 |=> s_tail)
    else $error("sequence order broken");
  chk_seq_start: assert property (seqCycle == irq_ctrl_pkg::SEQ_CYC1 |->
    $past(instrBoundary) && $past(seqCycle) == irq_ctrl_pkg::SEQ_IDLE)
    else $error("sequence started off a boundary");
  chk_finish_cyc1: assert property (finishInstr == (seqCycle == irq_ctrl_pkg::SEQ_CYC1))
    else $error("finish not in cycle one");
  chk_push_cycles: assert property (pushStack == (seqCycle == irq_ctrl_pkg::SEQ_CYC2 ||
    seqCycle == irq_ctrl_pkg::SEQ_CYC3))
    else $error("push outside cycles two and three");
  chk_load_cyc3: assert property (seqCycle == irq_ctrl_pkg::SEQ_CYC3 |-> loadVector)
    else $error("vector load not in cycle three");
  chk_load_stop: assert property (loadVector && seqCycle != irq_ctrl_pkg::SEQ_CYC3 |->
    seqCycle == irq_ctrl_pkg::SEQ_IDLE && vectorAddr == 14'h0000)
    else $error("stray vector load");
  chk_vector_hold: assert property (finishInstr |-> (!vectorAddr[0] &&
    vectorAddr inside {[14'h0002:14'h000E]}) ##1 s_vecHold)
    else $error("vector out of range or unstable");
  chk_restore_ret: assert property (restoreFlags == $past(returnFromIrqInstr))
    else $error("restore pulse mistimed");
  chk_bit_test: assert property (bitOpValid && bitOpCode == irq_ctrl_pkg::BITOP_TEST
    |=> bitTestValid)
    else $error("bit test answer missing");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not okay");
  chk_reset_idle: assert property ($fell(srst) |-> seqCycle == irq_ctrl_pkg::SEQ_IDLE &&
    !loadVector && vectorAddr == 14'h0000)
    else $error("not idle after reset");
endmodule

bind vectored_interrupt_control irq_ctrl_sva i_irq_ctrl_sva (
  .clk_sys(clk_sys), .srst(srst), .hreadyout(hreadyout), .hresp(hresp),
  .bitOpValid(bitOpValid), .bitOpCode(bitOpCode), .bitTestValid(bitTestValid),
  .instrBoundary(instrBoundary), .returnFromIrqInstr(returnFromIrqInstr),
  .finishInstr(finishInstr), .pushStack(pushStack), .loadVector(loadVector),
  .vectorAddr(vectorAddr), .restoreFlags(restoreFlags), .seqCycle(seqCycle)
);

// ---- tb/core_seq_model.sv ----
// Core sequencer model: instruction boundaries and return execution
`timescale 1ns/100ps
module core_seq_model #(
  parameter int GAP = 3
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Handler asks to return
  input  wire logic retReq,
  // To the controller
  output logic      instrBoundary,
  output logic      returnFromIrqInstr
);
  logic [3:0] cnt_q;

  // One boundary every GAP cycles, like a multi-cycle instruction
  always_ff @(posedge clk_sys)
  begin
    if (srst || cnt_q == 4'(GAP - 1))
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
    instrBoundary <= !srst && cnt_q == 4'(GAP - 1);
  end

  // Handler ends with the return instruction
  always_ff @(posedge clk_sys)
  begin
    returnFromIrqInstr <= !srst && retReq;
  end
endmodule

// ---- tb/tb_vectored_interrupt_control.sv ----
// Self-checking bench for the vectored interrupt control
`timescale 1ns/100ps
module tb_vectored_interrupt_control;
  logic        clk_sys, srst, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans, bitOpCode, bitOpAddr, bitOpBit, seqCycle;
  logic [2:0]  hsize, timerOverflow;
  logic [31:0] hwdata, hrdata, r;
  logic        extIrqZeroN, extIrqOneN, adcDone, serialDone, bitOpValid;
  logic        bitTestValid, bitTestResult, instrBoundary, returnFromIrqInstr, retReq;
  logic        finishInstr, pushStack, loadVector, restoreFlags, irqOut, got, v;
  logic [13:0] vectorAddr;
  logic [6:0]  msk, pend, ex;
  logic        evm, stopMode, stopCancelInput;
  int          n_fail, compares, s, it;

  vectored_interrupt_control i_vectored_interrupt_control (
    .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .extIrqZeroN(extIrqZeroN),
    .extIrqOneN(extIrqOneN), .timerOverflow(timerOverflow), .adcDone(adcDone),
    .serialDone(serialDone), .stopMode(stopMode), .stopCancelInput(stopCancelInput),
    .bitOpValid(bitOpValid), .bitOpCode(bitOpCode), .bitOpAddr(bitOpAddr),
    .bitOpBit(bitOpBit), .bitTestValid(bitTestValid), .bitTestResult(bitTestResult),
    .instrBoundary(instrBoundary), .returnFromIrqInstr(returnFromIrqInstr),
    .finishInstr(finishInstr), .pushStack(pushStack), .loadVector(loadVector),
    .vectorAddr(vectorAddr), .restoreFlags(restoreFlags), .seqCycle(seqCycle),
    .irqOut(irqOut));

  core_seq_model i_core_seq_model (
    .clk_sys(clk_sys), .srst(srst), .retReq(retReq), .instrBoundary(instrBoundary),
    .returnFromIrqInstr(returnFromIrqInstr));

  always #5 clk_sys = ~clk_sys;

  // ****************************************
  // Tasks and expectations
  // ****************************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Flag of source k sits at bit 2+2k, its mask at 3+2k
  task bop(input logic [1:0] c, input int pos);
    @(posedge clk_sys);
    bitOpValid <= 1'b1;
    bitOpCode <= c;
    bitOpAddr <= 2'(pos / 4);
    bitOpBit <= 2'(pos % 4);
    @(posedge clk_sys);
    bitOpValid <= 1'b0;
    #1;
    v = bitTestResult;
  endtask

  task fire(input int k);
    @(posedge clk_sys);
    extIrqZeroN <= (k != 0);
    extIrqOneN <= (k != 1);
    timerOverflow <= (k >= 2 && k <= 4) ? 3'(1 << (k - 2)) : 3'h0;
    adcDone <= (k == 5);
    serialDone <= (k == 6);
    @(posedge clk_sys);
    {timerOverflow, adcDone, serialDone} <= 5'h00;
    repeat (3) @(posedge clk_sys);
    {extIrqZeroN, extIrqOneN} <= 2'h3;
  endtask

  function automatic logic [13:0] expVec(input logic [6:0] p);
    expVec = 14'h0000;
    for (int k = 6; k >= 0; k--)
      if (p[k])
        expVec = 14'h0002 + 14'(2 * k);
  endfunction

  task wrap_up;
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {clk_sys, hsel, hwrite, bitOpValid, retReq, adcDone, serialDone} = 7'h00;
    {haddr, htrans, hsize, hwdata, timerOverflow} = '0;
    {bitOpCode, bitOpAddr, bitOpBit} = '0;
    {extIrqZeroN, extIrqOneN, srst} = 3'h7;
    {stopMode, stopCancelInput} = 2'h0;
    n_fail = 0;
    compares = 0;
    s = $urandom(51310);
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    hsize <= 3'h2;
    for (s = 0; s < 4; s++)
    begin
      ahb(1'b0, 8'(4 * s), 32'h0);
      chk("ctrl reset", (s == 0) ? 32'h8 : 32'hA, {28'h0, r[3:0]});
    end
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, r);
    for (s = 0; s < 4; s++)
    begin
      ahb(1'b1, 8'(4 * s), 32'hF);
      ahb(1'b0, 8'(4 * s), 32'h0);
      chk("sw flag set", (s == 0) ? 32'h9 : 32'hA, {28'h0, r[3:0]});
    end
    ahb(1'b1, 8'h00, 32'h8);
    bop(irq_ctrl_pkg::BITOP_SET, 2);
    bop(irq_ctrl_pkg::BITOP_TEST, 2);
    chk("bitop flag set", 32'h0, {31'h0, v});
    for (it = 0; it < 10; it++)
    begin
      msk = (it == 0) ? 7'h00 : 7'($urandom);
      pend = (it == 0) ? 7'h7F : ((it == 1) ? 7'h40 : 7'($urandom));
      evm = 1'($urandom);
      ahb(1'b1, 8'h14, {31'h0, evm});
      for (s = 0; s < 7; s++)
        bop(msk[s] ? irq_ctrl_pkg::BITOP_SET : irq_ctrl_pkg::BITOP_RESET, 3 + 2 * s);
      for (s = 0; s < 7; s++)
        if (pend[s])
          fire(s);
      repeat (6) @(posedge clk_sys);
      chk("held while disabled", irq_ctrl_pkg::SEQ_IDLE, seqCycle);
      bop(irq_ctrl_pkg::BITOP_SET, 0);
      ex = pend & ~msk;
      got = 1'b0;
      for (s = 0; s < 40 && !got; s++)
      begin
        @(posedge clk_sys);
        #1;
        got = loadVector;
      end
      chk("sequence ran", {31'h0, ex != 7'h00}, {31'h0, got});
      if (got)
      begin
        chk("vector", expVec(ex), vectorAddr);
        bop(irq_ctrl_pkg::BITOP_TEST, 0);
        chk("enable after entry", 32'h0, {31'h0, v});
        chk("irq level", {31'h0, evm}, {31'h0, irqOut});
        ahb(1'b0, 8'h10, 32'h0);
        chk("event status", 32'h1, {31'h0, r[0]});
        ahb(1'b0, 8'h10, 32'h0);
        chk("status cleared", 32'h0, {31'h0, r[0]});
      end
      for (s = 0; s < 7; s++)
        bop(irq_ctrl_pkg::BITOP_RESET, 2 + 2 * s);
      if (got)
      begin
        @(posedge clk_sys);
        retReq <= 1'b1;
        @(posedge clk_sys);
        retReq <= 1'b0;
        repeat (3) @(posedge clk_sys);
        bop(irq_ctrl_pkg::BITOP_TEST, 0);
        chk("enable after return", 32'h1, {31'h0, v});
      end
      bop(irq_ctrl_pkg::BITOP_RESET, 0);
    end
    // Stop cancel edge while in stop mode jumps to the reset vector
    @(posedge clk_sys);
    stopMode <= 1'b1;
    stopCancelInput <= 1'b1;
    got = 1'b0;
    for (s = 0; s < 10 && !got; s++)
    begin
      @(posedge clk_sys);
      #1;
      got = loadVector;
    end
    chk("stop cancel load", 32'h1, {31'h0, got});
    chk("stop cancel vector", 32'h0, {18'h0, vectorAddr});
    @(posedge clk_sys);
    {stopMode, stopCancelInput} <= 2'h0;
    repeat (4) @(posedge clk_sys);
    wrap_up();
  end
endmodule
